//--- smc_defs.svh
// Offsets, field positions, reset values and vector length limits for the streaming mode controller.
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH
`define SMC_REG_CTRL      4'h0
`define SMC_REG_STATUS    4'h1
`define SMC_REG_LEGAL     4'h2
`define SMC_REG_VLEN      4'h3
`define SMC_REG_COUNTS    4'h4
`define SMC_REG_FP_STATUS_REGISTER_LO   4'h5
`define SMC_REG_FP_STATUS_REGISTER_HI   4'h6
`define SMC_REG_OPTION    4'h7
`define SMC_REG_ZEROCNT   4'h8
`define SMC_BIT_SM        0
`define SMC_BIT_ZA        1
`define SMC_FP_STATUS_REGISTER_RESET    64'h0000_0000_0800_009f
`define SMC_SVL_MIN       12'h080
`define SMC_SVL_MAX       12'h800
`define SMC_SVL_RESET     12'h100
`endif

//--- smc_pkg.sv
// Types shared by the streaming mode controller.
package smc_pkg;
   typedef enum logic [2:0] {
      SMC_SEL_SM   = 3'h1,
      SMC_SEL_ZA   = 3'h2,
      SMC_SEL_BOTH = 3'h4
   } smc_sel_t;
   typedef enum logic [3:0] {
      SMC_CLS_SCALAR = 4'h0,
      SMC_CLS_SIMD   = 4'h1,
      SMC_CLS_VEC    = 4'h2,
      SMC_CLS_VECBAD = 4'h3,
      SMC_CLS_FFR    = 4'h4,
      SMC_CLS_STREAM = 4'h5,
      SMC_CLS_ZAVEC  = 4'h6,
      SMC_CLS_ZAOTH  = 4'h7,
      SMC_CLS_SVCR   = 4'h8
   } smc_cls_t;
   typedef struct packed {
      logic       valid;
      smc_cls_t   cls;
      logic       uses_regs;
   } smc_insn_t;
   typedef struct packed {
      logic       illegal;
      logic       streaming_bank;
      logic       ffr_visible;
   } smc_verdict_t;
endpackage : smc_pkg

//--- smc_ctrl.sv
// Streaming mode and matrix storage enable control with legality checking.
`timescale 1ns/100ps
`default_nettype none
`include "smc_defs.svh"
module smc_ctrl #(
   parameter logic [11:0] SVL_BITS = `SMC_SVL_RESET,
   parameter logic [11:0] NS_VL    = 12'h080
) (
   input  wire  logic                  CORE_CLK,
   input  wire  logic                  RST,
   input  wire  logic                  CE,
   input  wire  logic [3:0]            ADDR,
   input  wire  logic [31:0]           WDATA,
   input  wire  logic                  WR,
   input  wire  logic                  RD,
   output logic [31:0]                 RDATA,
   input  wire  logic                  IMM_WR,
   input  wire  smc_pkg::smc_sel_t     IMM_SEL,
   input  wire  logic                  IMM_VAL,
   input  wire  smc_pkg::smc_insn_t    INSN,
   output smc_pkg::smc_verdict_t       VERDICT,
   output logic                        STREAMING,
   output logic                        STORAGE_EN,
   output logic                        CLR_VECTOR_REGS,
   output logic                        CLR_MATRIX,
   output logic [63:0]                 FP_STATUS,
   output logic [11:0]                 EFF_VL
);
   logic        sm;
   logic        za;
   logic        fa64;
   logic [63:0] fp_status_register;
   logic [7:0]  zero_cnt;
   logic [31:0] rd_q;

   wire w_ctrl = CE & WR & (ADDR == `SMC_REG_CTRL);
   wire w_opt  = CE & WR & (ADDR == `SMC_REG_OPTION);
   wire w_flo  = CE & WR & (ADDR == `SMC_REG_FP_STATUS_REGISTER_LO);
   wire w_fhi  = CE & WR & (ADDR == `SMC_REG_FP_STATUS_REGISTER_HI);
   wire imm_sm = CE & IMM_WR & (IMM_SEL != smc_pkg::SMC_SEL_ZA);
   wire imm_za = CE & IMM_WR & (IMM_SEL != smc_pkg::SMC_SEL_SM);

   wire next_sm = w_ctrl ? WDATA[`SMC_BIT_SM] : (imm_sm ? IMM_VAL : sm);
   wire next_za = w_ctrl ? WDATA[`SMC_BIT_ZA] : (imm_za ? IMM_VAL : za);
   wire sm_chg  = CE & (next_sm != sm);
   wire za_rise = CE & next_za & ~za;

   wire [11:0] streaming_vector_length = (SVL_BITS < `SMC_SVL_MIN) ? `SMC_SVL_MIN :
                     (SVL_BITS > `SMC_SVL_MAX) ? `SMC_SVL_MAX : SVL_BITS;
   wire [8:0]  svl_b = streaming_vector_length[11:3];
   wire [7:0]  svl_h = streaming_vector_length[11:4];
   wire [6:0]  svl_s = streaming_vector_length[11:5];
   wire [5:0]  svl_d = streaming_vector_length[11:6];
   wire [4:0]  svl_q = streaming_vector_length[11:7];
   wire [31:0] counts = {svl_b[7:0], svl_h, 1'b0, svl_s, 3'h0, svl_q};

   wire cls_scalar = INSN.cls == smc_pkg::SMC_CLS_SCALAR;
   wire cls_simd   = INSN.cls == smc_pkg::SMC_CLS_SIMD;
   wire cls_vecbad = INSN.cls == smc_pkg::SMC_CLS_VECBAD;
   wire cls_ffr    = INSN.cls == smc_pkg::SMC_CLS_FFR;
   wire cls_stream = INSN.cls == smc_pkg::SMC_CLS_STREAM;
   wire cls_zavec  = INSN.cls == smc_pkg::SMC_CLS_ZAVEC;
   wire cls_zaoth  = INSN.cls == smc_pkg::SMC_CLS_ZAOTH;
   wire ffr_vis    = ~sm | fa64;
   wire ill_sm     = ~fa64 & (cls_simd | cls_vecbad | cls_ffr);
   wire ill_ns     = cls_stream | cls_zaoth;
   wire ill_za     = ~za & (cls_zavec | cls_zaoth);
   wire illegal    = INSN.valid & ((sm ? ill_sm : ill_ns) | ill_za);
   wire next_zc    = sm_chg & ~zero_cnt[7];

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         sm <= 1'b0;
         za <= 1'b0;
         fa64 <= 1'b0;
      end else if (CE) begin
         sm <= next_sm;
         za <= next_za;
         fa64 <= w_opt ? WDATA[0] : fa64;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         fp_status_register <= 64'h0;
      end else if (sm_chg) begin
         fp_status_register <= `SMC_FP_STATUS_REGISTER_RESET;
      end else if (w_flo) begin
         fp_status_register <= {fp_status_register[63:32], WDATA};
      end else if (w_fhi) begin
         fp_status_register <= {WDATA, fp_status_register[31:0]};
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         zero_cnt <= 8'h0;
      end else if (next_zc) begin
         zero_cnt <= zero_cnt + 8'h01;
      end
   end

   wire [31:0] rd_mux =
      (ADDR == `SMC_REG_CTRL)    ? {30'h0, za, sm} :
      (ADDR == `SMC_REG_STATUS)  ? {29'h0, ffr_vis, za, sm} :
      (ADDR == `SMC_REG_LEGAL)   ? {29'h0, VERDICT} :
      (ADDR == `SMC_REG_VLEN)    ? {20'h0, streaming_vector_length} :
      (ADDR == `SMC_REG_COUNTS)  ? counts :
      (ADDR == `SMC_REG_FP_STATUS_REGISTER_LO) ? fp_status_register[31:0] :
      (ADDR == `SMC_REG_FP_STATUS_REGISTER_HI) ? fp_status_register[63:32] :
      (ADDR == `SMC_REG_OPTION)  ? {31'h0, fa64} :
      (ADDR == `SMC_REG_ZEROCNT) ? {24'h0, zero_cnt} : 32'h0;

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         rd_q <= 32'h0;
      end else if (CE) begin
         rd_q <= RD ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         VERDICT <= '0;
         STREAMING <= 1'b0;
         STORAGE_EN <= 1'b0;
         CLR_VECTOR_REGS <= 1'b0;
         CLR_MATRIX <= 1'b0;
         FP_STATUS <= 64'h0;
         EFF_VL <= 12'h0;
      end else if (CE) begin
         VERDICT <= '{illegal: illegal, streaming_bank: sm & INSN.uses_regs, ffr_visible: ffr_vis};
         STREAMING <= next_sm;
         STORAGE_EN <= next_za;
         CLR_VECTOR_REGS <= sm_chg;
         CLR_MATRIX <= za_rise;
         FP_STATUS <= sm_chg ? `SMC_FP_STATUS_REGISTER_RESET : fp_status_register;
         EFF_VL <= next_sm ? streaming_vector_length : NS_VL;
      end
   end

   assign RDATA = rd_q;

   a_fp_status_register_on_change: assert property (@(posedge CORE_CLK) disable iff (RST)
      sm_chg |=> fp_status_register == `SMC_FP_STATUS_REGISTER_RESET)
      else $error("fp status not reset on mode change");
   a_clear_vectors: assert property (@(posedge CORE_CLK) disable iff (RST)
      (CE && $changed(sm)) |-> CLR_VECTOR_REGS)
      else $error("vector clear missing on mode change");
   a_za_rise_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
      (CE && $rose(za)) |-> CLR_MATRIX)
      else $error("matrix clear missing on enable");
   a_za_only_keeps: assert property (@(posedge CORE_CLK) disable iff (RST)
      (CE && $changed(za) && $stable(sm)) |-> !CLR_VECTOR_REGS)
      else $error("vector clear on enable change only");
   a_za_fall_quiet: assert property (@(posedge CORE_CLK) disable iff (RST)
      (CE && $fell(za)) |-> !CLR_MATRIX)
      else $error("matrix cleared on disable");
   a_stream_follows: assert property (@(posedge CORE_CLK) disable iff (RST)
      CE |=> STREAMING == sm)
      else $error("streaming output mismatch");
   a_za_illegal: assert property (@(posedge CORE_CLK) disable iff (RST)
      (CE && INSN.valid && !za && cls_zavec) |=> VERDICT.illegal)
      else $error("array access legal while disabled");
   a_ns_stream_ill: assert property (@(posedge CORE_CLK) disable iff (RST)
      (CE && INSN.valid && !sm && cls_stream) |=> VERDICT.illegal)
      else $error("streaming instruction legal outside mode");
   a_scalar_legal: assert property (@(posedge CORE_CLK) disable iff (RST)
      (CE && INSN.valid && cls_scalar) |=> !VERDICT.illegal)
      else $error("scalar instruction flagged illegal");
   a_vl_stream: assert property (@(posedge CORE_CLK) disable iff (RST)
      (CE && STREAMING) |-> EFF_VL == streaming_vector_length)
      else $error("effective length differs in streaming");
   c_enter: cover property (@(posedge CORE_CLK) disable iff (RST) CE && $rose(sm));
   c_exit: cover property (@(posedge CORE_CLK) disable iff (RST) CE && $fell(sm));
   c_za_on: cover property (@(posedge CORE_CLK) disable iff (RST) CE && $rose(za));
   c_ill: cover property (@(posedge CORE_CLK) disable iff (RST) VERDICT.illegal);
endmodule : smc_ctrl
`default_nettype wire

//--- smc_ctrl_tb.sv
// Self-checking testbench for the streaming mode controller.
`timescale 1ns/100ps
`default_nettype none
`include "smc_defs.svh"
module tb;
   logic                  core_clk = 1'b0;
   logic                  rst = 1'b1;
   logic                  ce = 1'b1;
   logic [3:0]            addr = 4'h0;
   logic [31:0]           wdata = 32'h0;
   logic                  wr = 1'b0;
   logic                  rd = 1'b0;
   logic                  imm_wr = 1'b0;
   logic                  imm_val = 1'b0;
   smc_pkg::smc_sel_t     imm_sel = smc_pkg::SMC_SEL_SM;
   smc_pkg::smc_insn_t    insn = '0;
   logic [31:0]           rdata;
   smc_pkg::smc_verdict_t verdict;
   logic                  streaming, storage_en, clr_v, clr_m;
   logic [63:0]           fp_status;
   logic [11:0]           eff_vl;
   logic                  sm = 1'b0, za = 1'b0, opt = 1'b0, fp_set = 1'b0;
   int                    num_errors = 0;
   int                    n_checks = 0;
   int                    n_chg = 0;

   smc_ctrl #(.SVL_BITS(12'h100), .NS_VL(12'h080)) uut (
      .CORE_CLK(core_clk), .RST(rst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .IMM_WR(imm_wr), .IMM_SEL(imm_sel), .IMM_VAL(imm_val),
      .INSN(insn), .VERDICT(verdict), .STREAMING(streaming), .STORAGE_EN(storage_en),
      .CLR_VECTOR_REGS(clr_v), .CLR_MATRIX(clr_m), .FP_STATUS(fp_status), .EFF_VL(eff_vl));

   always #50 core_clk = ~core_clk;

   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : chk

   task automatic complete_run;
      $display("checks %0d, mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run

   // Illegal flag, bank choice and first-fault visibility for one class in one state.
   function automatic logic [2:0] exp_verdict(input logic [3:0] c, input logic s,
                                              input logic z, input logic o);
      logic ill;
      case (c)
         4'h1, 4'h3, 4'h4: ill = s & ~o;
         4'h5:             ill = ~s;
         4'h6:             ill = ~z;
         4'h7:             ill = ~z | ~s;
         default:          ill = 1'b0;
      endcase
      return {ill, s, ~s | o};
   endfunction : exp_verdict

   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge core_clk);
      wr <= 1'b0;
      #1;
   endtask : wreg

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string name);
      @(posedge core_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge core_clk);
      rd <= 1'b0;
      #1;
      chk(name, exp, rdata);
   endtask : rd_chk

   // Register form takes sel as the two control bits; immediate form takes it as a selector.
   task automatic change(input logic by_reg, input logic [1:0] sel, input logic v);
      logic osm, oza;
      osm = sm;
      oza = za;
      if (by_reg) begin
         sm = sel[0];
         za = sel[1];
         wreg(4'h0, {30'h0, sel});
      end else begin
         if (sel != 2'd1) sm = v;
         if (sel != 2'd0) za = v;
         @(posedge core_clk);
         imm_wr <= 1'b1;
         imm_val <= v;
         imm_sel <= (sel == 2'd0) ? smc_pkg::SMC_SEL_SM :
                    (sel == 2'd1) ? smc_pkg::SMC_SEL_ZA : smc_pkg::SMC_SEL_BOTH;
         @(posedge core_clk);
         imm_wr <= 1'b0;
         #1;
      end
      if (sm != osm) begin
         fp_set = 1'b1;
         if (n_chg < 128) n_chg++;
      end
      chk("streaming", sm, streaming);
      chk("storage_en", za, storage_en);
      chk("clr_vector", sm != osm, clr_v);
      chk("clr_matrix", za & ~oza, clr_m);
      chk("fp_status", fp_set ? `SMC_FP_STATUS_REGISTER_RESET : 64'h0, fp_status);
      chk("eff_vl", sm ? 12'h100 : 12'h080, eff_vl);
   endtask : change

   initial begin
      logic r;
      void'($urandom(32'h8508));
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      #1;
      chk("reset bits", 4'h0, {streaming, storage_en, clr_v, clr_m});
      $display("test reset done");
      change(1'b1, 2'h1, 1'b0);
      change(1'b0, 2'd2, 1'b1);
      change(1'b0, 2'd2, 1'b0);
      change(1'b0, 2'd1, 1'b1);
      for (int i = 0; i < 40; i++) begin
         r = 1'($urandom_range(0, 1));
         change(r, 2'($urandom_range(0, r ? 3 : 2)), 1'($urandom_range(0, 1)));
      end
      rd_chk(4'h0, {30'h0, za, sm}, "ctrl readback");
      $display("test mode changes done");
      for (int o = 0; o < 2; o++) begin
         opt = o[0];
         wreg(4'h7, {31'h0, opt});
         for (int st = 0; st < 4; st++) begin
            change(1'b1, st[1:0], 1'b0);
            for (int c = 0; c < 9; c++) begin
               @(posedge core_clk);
               insn <= '{valid: 1'b1, cls: smc_pkg::smc_cls_t'(c[3:0]), uses_regs: 1'b1};
               @(posedge core_clk);
               #1;
               chk("verdict", exp_verdict(c[3:0], sm, za, opt), verdict);
            end
         end
      end
      rd_chk(4'h1, {29'h0, ~sm | opt, za, sm}, "status");
      rd_chk(4'h2, {29'h0, verdict}, "last verdict");
      $display("test legality done");
      @(posedge core_clk);
      ce <= 1'b0;
      wreg(4'h0, {30'h0, ~za, ~sm});
      chk("streaming frozen", sm, streaming);
      @(posedge core_clk);
      ce <= 1'b1;
      rd_chk(4'h0, {30'h0, za, sm}, "ctrl after frozen write");
      $display("test clock enable done");
      wreg(4'hc, 32'hffff_ffff);
      rd_chk(4'h0, {30'h0, za, sm}, "ctrl after unmapped write");
      rd_chk(4'hc, 32'h0, "unmapped read");
      rd_chk(4'h3, 32'h100, "streaming length");
      rd_chk(4'h5, 32'h0800_009f, "fp status low");
      rd_chk(4'h6, 32'h0, "fp status high");
      rd_chk(4'h4, 32'h2010_0802, "element counts");
      rd_chk(4'h7, {31'h0, opt}, "option readback");
      rd_chk(4'h8, n_chg, "mode change count");
      wreg(4'h5, 32'h1234_5678);
      rd_chk(4'h5, 32'h1234_5678, "fp status written");
      $display("test register reads done");
      complete_run();
   end

   initial begin
      repeat (5000) @(posedge core_clk);
      num_errors++;
      complete_run();
   end
endmodule : tb
`default_nettype wire
